/* rtl/panic_error_aggregator.sv */
// Error mask, sticky master flag, first-error code and APB slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module panic_error_aggregator
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] parityErr,
  input  wire logic        softwareErr,
  input  wire logic        watchdogErr,
  input  wire logic        stackErr,
  input  wire logic        loopErr,
  output logic             errorFlag,
  output logic             irq
);
  localparam int PW = error_aggregator_pkg::PARITY_W;
  localparam int SW = error_aggregator_pkg::SRC_W;

  logic [PW-1:0] parityMask_ff;
  logic          softwareMask_ff;
  logic          watchdogMask_ff;
  logic          stackMask_ff;
  logic          loopMask_ff;
  logic          clearBit_ff;
  logic          flag_ff;
  logic [SW-1:0] code_ff;
  logic          irqStat_ff;
  logic          irqMask_ff;
  logic [SW-1:0] errSync1_ff;
  logic [SW-1:0] errSync2_ff;
  logic [SW-1:0] rawErr;
  logic [SW-1:0] srcMask;
  logic [SW-1:0] unmasked;
  logic          anyErr;
  logic [15:0]   idx;
  logic          access;
  logic          wrAcc;
  logic          clearRise;
  logic          mapped;
  logic [31:0]   nxt_prdata;

  // Lane 0 carries bit 0 of every control register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  assign idx    = paddr[error_aggregator_pkg::ADDR_LSB +: error_aggregator_pkg::IDX_W];
  assign access = psel && penable && !pready;
  // Writes land only at the edge where the master sees pready high
  assign wrAcc  = psel && penable && pready && pwrite;

  // Error sources come from other logic, so two flops before use
  assign rawErr = {softwareErr, loopErr, stackErr, watchdogErr, parityErr};
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      errSync1_ff <= error_aggregator_pkg::ZERO16;
      errSync2_ff <= error_aggregator_pkg::ZERO16;
    end
    else if (clkEn)
    begin
      errSync1_ff <= rawErr;
      errSync2_ff <= errSync1_ff;
    end
  end

  // Mask bit of one means suppressed
  always_comb
  begin
    srcMask = error_aggregator_pkg::ZERO16;
    srcMask[PW-1:0] = parityMask_ff;
    srcMask[error_aggregator_pkg::SOFTWARE_BIT] = softwareMask_ff;
    srcMask[error_aggregator_pkg::WATCHDOG_BIT] = watchdogMask_ff;
    srcMask[error_aggregator_pkg::STACK_BIT]    = stackMask_ff;
    srcMask[error_aggregator_pkg::LOOP_BIT]     = loopMask_ff;
  end
  assign unmasked = errSync2_ff & ~srcMask;
  assign anyErr   = |unmasked;

  // Mask registers written over the bus
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      parityMask_ff   <= error_aggregator_pkg::PARITY_RST;
      softwareMask_ff <= 1'b0;
      watchdogMask_ff <= 1'b0;
      stackMask_ff    <= 1'b0;
      loopMask_ff     <= 1'b0;
      irqMask_ff      <= 1'b0;
    end
    else if (clkEn && wrAcc)
    begin
      unique case (idx)
        error_aggregator_pkg::PARITY_IDX:
          parityMask_ff <= PW'(merge16({4'h0, parityMask_ff}, pwdata, pstrb));
        error_aggregator_pkg::SOFTWARE_IDX:
          if (pstrb[0]) softwareMask_ff <= pwdata[0];
        error_aggregator_pkg::WATCHDOG_IDX:
          if (pstrb[0]) watchdogMask_ff <= pwdata[0];
        error_aggregator_pkg::STACK_IDX:
          if (pstrb[0]) stackMask_ff <= pwdata[0];
        error_aggregator_pkg::LOOP_IDX:
          if (pstrb[0]) loopMask_ff <= pwdata[0];
        error_aggregator_pkg::IRQ_MASK_IDX:
          if (pstrb[0]) irqMask_ff <= pwdata[0];
        default:
          ;
      endcase
    end
  end

  // Clear register bit; only its rising edge does anything
  assign clearRise = wrAcc && pstrb[0] && (idx == error_aggregator_pkg::CLEAR_IDX)
                     && pwdata[0] && !clearBit_ff;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clearBit_ff <= 1'b0;
    else if (clkEn && wrAcc && pstrb[0] && idx == error_aggregator_pkg::CLEAR_IDX)
      clearBit_ff <= pwdata[0];
  end

  // Sticky flag; a new error in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flag_ff <= 1'b0;
    else if (clkEn)
    begin
      if (anyErr)
        flag_ff <= 1'b1;
      else if (clearRise)
        flag_ff <= 1'b0;
    end
  end

  // First-error code frozen while the flag stands until a clear edge, which reloads it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      code_ff <= error_aggregator_pkg::ZERO16;
    else if (clkEn)
    begin
      if (anyErr && (!flag_ff || clearRise))
        code_ff <= unmasked;
      else if (clearRise)
        code_ff <= error_aggregator_pkg::ZERO16;
    end
  end

  // Interrupt status: set on each new flag event, write one to clear, set wins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irqStat_ff <= 1'b0;
    else if (clkEn)
    begin
      if (anyErr && !flag_ff)
        irqStat_ff <= 1'b1;
      else if (wrAcc && pstrb[0] && idx == error_aggregator_pkg::IRQ_STAT_IDX && pwdata[0])
        irqStat_ff <= 1'b0;
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb
  begin
    mapped     = 1'b1;
    nxt_prdata = 32'h0000_0000;
    unique case (idx)
      error_aggregator_pkg::CLEAR_IDX:    nxt_prdata[0] = clearBit_ff;
      error_aggregator_pkg::PARITY_IDX:   nxt_prdata[PW-1:0] = parityMask_ff;
      error_aggregator_pkg::SOFTWARE_IDX: nxt_prdata[0] = softwareMask_ff;
      error_aggregator_pkg::WATCHDOG_IDX: nxt_prdata[0] = watchdogMask_ff;
      error_aggregator_pkg::STACK_IDX:    nxt_prdata[0] = stackMask_ff;
      error_aggregator_pkg::LOOP_IDX:     nxt_prdata[0] = loopMask_ff;
      error_aggregator_pkg::FLAG_IDX:     nxt_prdata[0] = flag_ff;
      error_aggregator_pkg::CODE_IDX:     nxt_prdata[SW-1:0] = code_ff;
      error_aggregator_pkg::IRQ_STAT_IDX: nxt_prdata[0] = irqStat_ff;
      error_aggregator_pkg::IRQ_MASK_IDX: nxt_prdata[0] = irqMask_ff;
      default:                            mapped = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      pready  <= access;
      pslverr <= access && !mapped;
      prdata  <= (access && !pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  // Outputs straight from flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      errorFlag <= 1'b0;
      irq       <= 1'b0;
    end
    else if (clkEn)
    begin
      errorFlag <= flag_ff;
      irq       <= irqStat_ff && irqMask_ff;
    end
  end

  // Checks
  sequence errSeen_s;
    clkEn && anyErr;
  endsequence

  flagSet_a: assert property (@(posedge clk) disable iff (!rstn)
    errSeen_s |=> flag_ff)
    else $error("unmasked error did not set flag");
  flagSticky_a: assert property (@(posedge clk) disable iff (!rstn)
    flag_ff && !clearRise |=> flag_ff)
    else $error("flag dropped without clear");
  flagRise_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flag_ff) |-> $past(anyErr))
    else $error("flag rose without unmasked error");
  maskedNoSet_a: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && !flag_ff && (errSync2_ff & ~srcMask) == 16'h0000 |=> !flag_ff)
    else $error("masked error set flag");
  clearEdge_a: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && clearRise && !anyErr |=> !flag_ff)
    else $error("clear edge did not clear flag");
  codeHold_a: assert property (@(posedge clk) disable iff (!rstn)
    flag_ff && !clearRise |=> $stable(code_ff))
    else $error("code changed while flag stands");
  rateMask_a: assert property (@(posedge clk) disable iff (!rstn)
    parityMask_ff[0] |-> !unmasked[error_aggregator_pkg::RATE_LSB])
    else $error("masked converter error passed");
  flagOut_a: assert property (@(posedge clk) disable iff (!rstn)
    clkEn |=> errorFlag == $past(flag_ff))
    else $error("flag output mismatch");
  busReady_a: assert property (@(posedge clk) disable iff (!rstn)
    clkEn && access ##1 clkEn |-> pready)
    else $error("pready late");
endmodule

/* rtl/error_aggregator_pkg.sv */
// Register map, field layout and reset values of the error aggregator
package error_aggregator_pkg;
  // Printed offsets are word indices; byte address is four times the index
  localparam logic [15:0] CLEAR_IDX    = 16'hf421;
  localparam logic [15:0] PARITY_IDX   = 16'hf422;
  localparam logic [15:0] SOFTWARE_IDX = 16'hf423;
  localparam logic [15:0] WATCHDOG_IDX = 16'hf424;
  localparam logic [15:0] STACK_IDX    = 16'hf425;
  localparam logic [15:0] LOOP_IDX     = 16'hf426;
  localparam logic [15:0] FLAG_IDX     = 16'hf427;
  localparam logic [15:0] CODE_IDX     = 16'hf428;
  localparam logic [15:0] IRQ_STAT_IDX = 16'hf480;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hf481;
  localparam int          ADDR_LSB     = 2;
  localparam int          IDX_W        = 16;
  // Field layout
  localparam int          PARITY_W     = 12;
  localparam int          DRAM_B_LSB   = 8;
  localparam int          DRAM_A_LSB   = 4;
  localparam int          PRAM_LSB     = 2;
  localparam int          RATE_LSB     = 0;
  localparam int          SRC_W        = 16;
  localparam int          WATCHDOG_BIT = 12;
  localparam int          STACK_BIT    = 13;
  localparam int          LOOP_BIT     = 14;
  localparam int          SOFTWARE_BIT = 15;
  // Reset values
  localparam logic [PARITY_W-1:0] PARITY_RST = 12'h003;
  localparam logic [15:0]         ZERO16     = 16'h0000;
endpackage

/* bench/panic_error_aggregator_bench.sv */
// Self-checking APB bench for the panic error aggregator
`timescale 1ns/1ps
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) bad(); end
module panic_error_aggregator_bench;
  logic        clk     = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [15:0] srcE    = 16'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        errorFlag;
  logic        irq;
  int          nFail      = 0;
  int          checkCount = 0;

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  // Source vector follows the code register layout
  panic_error_aggregator panic_error_aggregator_inst
  (
    .clk(clk), .rstn(rstn), .clkEn(1'b1), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .parityErr(srcE[11:0]), .watchdogErr(srcE[12]), .stackErr(srcE[13]),
    .loopErr(srcE[14]), .softwareErr(srcE[15]), .errorFlag(errorFlag), .irq(irq)
  );

  task automatic bad();
    nFail++;
    $display("Error %0t: value mismatch", $time);
  endtask

  task automatic conclude();
    if (nFail == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; pready sampled at the rising edge, request held until then
  task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {14'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic setErr(input logic [15:0] s);
    @(posedge clk);
    srcE <= s;
  endtask

  // Mask register that governs source i
  function automatic logic [15:0] mIdx(input int i);
    if (i < 12)
      return error_aggregator_pkg::PARITY_IDX;
    case (i)
      12:      return error_aggregator_pkg::WATCHDOG_IDX;
      13:      return error_aggregator_pkg::STACK_IDX;
      14:      return error_aggregator_pkg::LOOP_IDX;
      default: return error_aggregator_pkg::SOFTWARE_IDX;
    endcase
  endfunction

  // Hang guard, well beyond the expected run length
  initial
  begin
    #1000000;
    bad();
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    // Reset values
    apb(error_aggregator_pkg::PARITY_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h3)
    for (int i = 12; i < 16; i++)
    begin
      apb(mIdx(i), 1'b0, 32'h0);
      `CHK(rd, 32'h0)
    end
    apb(error_aggregator_pkg::FLAG_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    // Converter A starts suppressed
    setErr(16'h0001);
    waitc(8);
    `CHK(errorFlag, 1'b0)
    setErr(16'h0);
    // Unmapped index refused
    apb(16'h0100, 1'b1, 32'hffff);
    `CHK(er, 1'b1)
    // Parity mask layout reads back
    apb(error_aggregator_pkg::PARITY_IDX, 1'b1, 32'h0fff);
    apb(error_aggregator_pkg::PARITY_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h0fff)
    apb(error_aggregator_pkg::PARITY_IDX, 1'b1, 32'h0);
    // Each source: masked is silent, unmasked sets the sticky flag
    for (int i = 0; i < 16; i++)
    begin
      apb(mIdx(i), 1'b1, (i < 12) ? (32'h1 << i) : 32'h1);
      setErr(16'h1 << i);
      waitc(8);
      `CHK(errorFlag, 1'b0)
      apb(mIdx(i), 1'b1, 32'h0);
      waitc(6);
      `CHK(errorFlag, 1'b1)
      setErr(16'h0);
      waitc(6);
      `CHK(errorFlag, 1'b1)
      apb(error_aggregator_pkg::CLEAR_IDX, 1'b1, 32'h1);
      apb(error_aggregator_pkg::CLEAR_IDX, 1'b1, 32'h0);
      waitc(2);
      `CHK(errorFlag, 1'b0)
    end
    // Latency, first source kept, flag not writable
    apb(error_aggregator_pkg::IRQ_MASK_IDX, 1'b1, 32'h1);
    setErr(16'h1000);
    waitc(1);
    `CHK(errorFlag, 1'b0)
    waitc(5);
    `CHK(errorFlag, 1'b1)
    setErr(16'h3000);
    waitc(6);
    apb(error_aggregator_pkg::CODE_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h1000)
    apb(error_aggregator_pkg::FLAG_IDX, 1'b1, 32'h0);
    apb(error_aggregator_pkg::FLAG_IDX, 1'b0, 32'h0);
    `CHK(rd, 32'h1)
    setErr(16'h0);
    waitc(4);
    // Only a rising edge of the clear bit clears
    apb(error_aggregator_pkg::CLEAR_IDX, 1'b1, 32'h1);
    setErr(16'h8000);
    waitc(6);
    setErr(16'h0);
    apb(error_aggregator_pkg::CLEAR_IDX, 1'b1, 32'h1);
    waitc(2);
    `CHK(errorFlag, 1'b1)
    apb(error_aggregator_pkg::CLEAR_IDX, 1'b1, 32'h0);
    apb(error_aggregator_pkg::CLEAR_IDX, 1'b1, 32'h1);
    waitc(2);
    `CHK(errorFlag, 1'b0)
    // Interrupt: status sticky, masked, then written back
    `CHK(irq, 1'b1)
    apb(error_aggregator_pkg::IRQ_MASK_IDX, 1'b1, 32'h0);
    waitc(2);
    `CHK(irq, 1'b0)
    apb(error_aggregator_pkg::IRQ_MASK_IDX, 1'b1, 32'h1);
    apb(error_aggregator_pkg::IRQ_STAT_IDX, 1'b1, 32'h1);
    waitc(2);
    `CHK(irq, 1'b0)
    conclude();
  end
endmodule
